// [rtl/lbi_pkg.sv]
// Package for the local bus interrupt status and enable block.
// Assumes a 32-bit local register port on a single core clock.
package lbi_pkg;

    localparam int unsigned LBI_DATA_W = 32;
    localparam int unsigned LBI_ADDR_W = 12;
    localparam int unsigned LBI_FLAG_W = 18;

    // Local bus byte addresses.
    localparam logic [11:0] LBI_ENABLE_ADDR = 12'h000;
    localparam logic [11:0] LBI_FLAGS_ADDR  = 12'h004;

    // Field positions shared by flags and enables.
    localparam int unsigned LBI_POWER_FAIL_BIT = 0;
    localparam int unsigned LBI_SYS_FAIL_BIT   = 1;
    localparam int unsigned LBI_LEVEL7_BIT     = 2;
    localparam int unsigned LBI_LEVEL1_BIT     = 8;
    localparam int unsigned LBI_SOFT_ACK_BIT   = 9;
    localparam int unsigned LBI_DMA_DONE_BIT   = 10;
    localparam int unsigned LBI_DMA_ERR_BIT    = 11;
    localparam int unsigned LBI_BUS_ERR_BIT    = 12;
    localparam int unsigned LBI_ARB_TMO_BIT    = 13;
    localparam int unsigned LBI_MBOX0_BIT      = 14;
    localparam int unsigned LBI_MBOX3_BIT      = 17;
    localparam int unsigned LBI_SOFT_REQ_EN_BIT = 0;

    // Values after reset.
    localparam logic [17:0] LBI_FLAGS_RESET  = 18'h00000;
    localparam logic [17:0] LBI_ENABLE_RESET = 18'h00000;
    localparam logic        LBI_SOFT_EN_RESET = 1'b0;

    // Levels 1..7 served-flag mask (bits 8 down to 2).
    localparam logic [17:0] LBI_LEVEL_MASK = 18'h001fc;

    typedef logic [17:0] lbi_vec_t;

endpackage : lbi_pkg

// [rtl/lbi_sync.sv]
// Two flip-flop synchroniser for a vector of asynchronous level inputs.
// Assumes the inputs come from pins outside the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module lbi_sync #(
    parameter int unsigned WIDTH = 2
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             resetn,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } lbi_sync_state_t;

    lbi_sync_state_t state;
    lbi_sync_state_t next_state;

    always_comb begin
        next_state.stage1 = async_in;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stage2;
endmodule : lbi_sync
`default_nettype wire

// [rtl/lbi_core.sv]
// Local bus interrupt status and enable logic: sticky event flags,
// per-source enables, one level interrupt request to the local CPU,
// and per-level gating of the VME interrupt handler.
// Assumes event inputs are one-cycle or level strobes from core_clk logic,
// except the failure lines which arrive from pins and are synchronised.
//
// Behaviour
// - Soft request enable bit gates VME request
// - Mailbox writes set flags 14 to 17
// - Arbiter timeout sets flag bit 13
// - Bus timer or BERR sets bit 12
// - DMA abort on error sets bit 11
// - DMA success sets flag bit 10
// - Served soft request sets flag bit 9
// - Levels 1..7 served flags bits 8..2
// - SYSFAIL asserted sets flag bit 1
// - ACFAIL asserted sets flag bit 0
// - Pending sources read back as one
// - Writing one clears; zero leaves unchanged
// - Flags latch freely; level flags need enable
// - Any enabled set flag raises interrupt
// - Enable bits mirror flag positions
// - Level enable activates that level handler
// - Mailbox write raises interrupt when enabled
`timescale 1ns/1ps
`default_nettype none
module lbi_core
    import lbi_pkg::*;
(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    // Local register port
    input  wire logic [LBI_ADDR_W-1:0] reg_addr,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    input  wire logic [LBI_DATA_W-1:0] reg_wdata,
    output logic      [LBI_DATA_W-1:0] reg_rdata,
    // Software interrupt request enable of the VME interrupter
    input  wire logic                  soft_enable_write,
    input  wire logic                  soft_enable_wdata,
    output logic                       vme_soft_request_enable,
    input  wire logic                  soft_request_pending,
    output logic                       vme_soft_request_out,
    // Event strobes from core logic
    input  wire logic [3:0]            mailbox_write,
    input  wire logic                  arbiter_timeout,
    input  wire logic                  bus_timer_expired,
    input  wire logic                  vme_berr_seen,
    input  wire logic                  dma_aborted,
    input  wire logic                  dma_done,
    input  wire logic                  soft_request_served,
    input  wire logic [7:1]            level_served,
    // Failure lines from pins, active high after pin inversion
    input  wire logic                  sysfail_pin,
    input  wire logic                  acfail_pin,
    // Outputs
    output logic [7:1]                 level_handler_enable,
    output logic                       local_irq
);

    typedef struct packed {
        lbi_vec_t  flags;
        lbi_vec_t  enables;
        logic      soft_en;
        logic      irq;
        logic [31:0] rdata;
    } lbi_core_state_t;

    lbi_core_state_t state;
    lbi_core_state_t next_state;

    logic [1:0] fail_sync;

    lbi_sync #(
        .WIDTH (2)
    ) u_fail_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .async_in ({sysfail_pin, acfail_pin}),
        .sync_out (fail_sync)
    );

    // Widens an 18-bit register image onto the 32-bit data bus.
    function automatic logic [31:0] widen(input lbi_vec_t v);
        widen = {14'h0000, v};
    endfunction : widen

    // Places a per-level vector into the descending flag layout.
    function automatic lbi_vec_t level_to_vec(input logic [7:1] lv);
        lbi_vec_t v;
        v = '0;
        for (int n = 1; n <= 7; n++) begin
            v[LBI_LEVEL1_BIT + 1 - n] = lv[n];
        end
        level_to_vec = v;
    endfunction : level_to_vec

    lbi_vec_t set_vec;
    lbi_vec_t clr_vec;
    logic     wr_flags;
    logic     wr_enable;

    always_comb begin
        set_vec = '0;
        set_vec[LBI_MBOX3_BIT:LBI_MBOX0_BIT] = mailbox_write;
        set_vec[LBI_ARB_TMO_BIT]  = arbiter_timeout;
        set_vec[LBI_BUS_ERR_BIT]  = bus_timer_expired | vme_berr_seen;
        set_vec[LBI_DMA_ERR_BIT]  = dma_aborted;
        set_vec[LBI_DMA_DONE_BIT] = dma_done;
        set_vec[LBI_SOFT_ACK_BIT] = soft_request_served;
        // Served-level flags follow only enabled levels.
        set_vec = set_vec | (level_to_vec(level_served) & state.enables);
        set_vec[LBI_SYS_FAIL_BIT]   = fail_sync[1];
        set_vec[LBI_POWER_FAIL_BIT] = fail_sync[0];
    end

    assign wr_flags  = reg_write && (reg_addr == LBI_FLAGS_ADDR);
    assign wr_enable = reg_write && (reg_addr == LBI_ENABLE_ADDR);
    assign clr_vec   = wr_flags ? reg_wdata[LBI_FLAG_W-1:0] : '0;

    always_comb begin
        next_state = state;
        // A new event in the clearing cycle keeps its flag set.
        next_state.flags = (state.flags & ~clr_vec) | set_vec;
        if (wr_enable) begin
            next_state.enables = reg_wdata[LBI_FLAG_W-1:0];
        end
        if (soft_enable_write) begin
            next_state.soft_en = soft_enable_wdata;
        end
        next_state.irq = |(next_state.flags & next_state.enables);
        next_state.rdata = '0;
        if (reg_read) begin
            case (reg_addr)
                LBI_ENABLE_ADDR: next_state.rdata = widen(state.enables);
                LBI_FLAGS_ADDR:  next_state.rdata = widen(state.flags);
                default:         next_state.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state.flags   <= LBI_FLAGS_RESET;
            state.enables <= LBI_ENABLE_RESET;
            state.soft_en <= LBI_SOFT_EN_RESET;
            state.irq     <= 1'b0;
            state.rdata   <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata               = state.rdata;
    assign local_irq               = state.irq;
    assign vme_soft_request_enable = state.soft_en;
    assign vme_soft_request_out    = state.soft_en & soft_request_pending;

    always_comb begin
        for (int n = 1; n <= 7; n++) begin
            level_handler_enable[n] = state.enables[LBI_LEVEL1_BIT + 1 - n];
        end
    end

endmodule : lbi_core
`default_nettype wire

// [tb/lbi_props.sv]
// Checker for the ports of the local bus interrupt block.
// Assumes it is bound to lbi_core and shares its single clock and reset.
`timescale 1ns/1ps
`default_nettype none
module lbi_props
    import lbi_pkg::*;
(
    input wire logic        core_clk, resetn, reg_write, reg_read, soft_enable_write,
    input wire logic        soft_enable_wdata, vme_soft_request_enable, soft_request_pending,
    input wire logic        vme_soft_request_out, arbiter_timeout, bus_timer_expired,
    input wire logic        vme_berr_seen, dma_aborted, dma_done, soft_request_served,
    input wire logic        sysfail_pin, acfail_pin, local_irq,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata, reg_rdata,
    input wire logic [3:0]  mailbox_write,
    input wire logic [7:1]  level_served, level_handler_enable
);
    logic [31:0] wd_q;
    logic        ev;
    logic        en_wr;
    assign ev = |{mailbox_write, arbiter_timeout, bus_timer_expired, vme_berr_seen,
                  dma_aborted, dma_done, soft_request_served, level_served};
    assign en_wr = reg_write && reg_addr == LBI_ENABLE_ADDR;
    always_ff @(posedge core_clk) wd_q <= reg_wdata;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside answer");
    a_rsvd_zero: assert property (reg_rdata[31:18] == 14'h0)
        else $error("reserved read bits not zero");
    a_soft_gate: assert property (vme_soft_request_out ==
        (vme_soft_request_enable && soft_request_pending)) else $error("soft request gate");
    a_soft_load: assert property (soft_enable_write |=>
        vme_soft_request_enable == $past(soft_enable_wdata)) else $error("soft enable load");
    a_level_map: assert property (en_wr |=> level_handler_enable ==
        {wd_q[2], wd_q[3], wd_q[4], wd_q[5], wd_q[6], wd_q[7], wd_q[8]})
        else $error("level handler enable map");
    a_irq_fall: assert property ($fell(local_irq) |-> $past(reg_write))
        else $error("irq dropped without a write");
    a_irq_rise: assert property ($rose(local_irq) |-> $past(ev) || $past(reg_write)
        || $past(sysfail_pin, 2) || $past(acfail_pin, 2)) else $error("irq rose without cause");
    a_irq_off: assert property (en_wr && reg_wdata[17:0] == 18'h0 |=> !local_irq)
        else $error("irq high with all enables clear");
    c_irq: cover property ($rose(local_irq));
    c_read: cover property (reg_read && reg_addr == LBI_FLAGS_ADDR);
    c_soft: cover property (vme_soft_request_out);
endmodule : lbi_props
bind lbi_core lbi_props chk_u (.*);
`default_nettype wire

// [tb/lbi_cpu.sv]
// Local CPU model that counts interrupt requests it receives.
// Assumes local_irq is a level on core_clk.
`timescale 1ns/1ps
`default_nettype none
module lbi_cpu (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       local_irq,
    output logic      [7:0] irq_count
);
    logic irq_q;
    always_ff @(posedge core_clk) begin
        irq_q <= resetn & local_irq;
        if (!resetn) irq_count <= 8'h00;
        else if (local_irq && !irq_q) irq_count <= irq_count + 8'h01;
    end
endmodule : lbi_cpu
`default_nettype wire

// [tb/tb_top.sv]
// Testbench for the interrupt block: register tasks and event strobes.
// Assumes lbi_core, lbi_cpu and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lbi_pkg::*;
    logic        core_clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic        soft_enable_write = 1'b0, soft_enable_wdata = 1'b0, soft_request_pending = 1'b0;
    logic        soft_en, soft_out, local_irq;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [18:0] ev = 19'h0;
    logic [7:1]  lvl_en;
    logic [7:0]  irq_count;
    int          err_total = 0, checked = 0;
    lbi_core dut_u (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .soft_enable_write(soft_enable_write), .soft_enable_wdata(soft_enable_wdata),
        .vme_soft_request_enable(soft_en), .soft_request_pending(soft_request_pending),
        .vme_soft_request_out(soft_out), .mailbox_write(ev[17:14]), .arbiter_timeout(ev[13]),
        .bus_timer_expired(ev[12]), .vme_berr_seen(ev[18]), .dma_aborted(ev[11]),
        .dma_done(ev[10]), .soft_request_served(ev[9]),
        .level_served({ev[2], ev[3], ev[4], ev[5], ev[6], ev[7], ev[8]}),
        .sysfail_pin(ev[1]), .acfail_pin(ev[0]), .level_handler_enable(lvl_en),
        .local_irq(local_irq));
    lbi_cpu cpu_u (.core_clk(core_clk), .resetn(resetn), .local_irq(local_irq),
        .irq_count(irq_count));
    task automatic close_out;
        if (err_total == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge core_clk);
        reg_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(negedge core_clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge core_clk);
        reg_read = 0;
        chk("reg_rdata", reg_rdata, e);
    endtask : rd
    // Failure pins need three edges to reach the flag, so every event is held that long.
    task automatic ev_go(input logic [18:0] v);
        @(negedge core_clk);
        ev = v;
        repeat (3) @(negedge core_clk);
        ev = 19'h0;
        repeat (4) @(negedge core_clk);
    endtask : ev_go
    initial forever #20 core_clk = ~core_clk;
    initial begin
        #100000;
        err_total++;
        close_out();
    end
    initial begin
        int          fb;
        logic        lvl;
        logic [31:0] m;
        repeat (5) @(negedge core_clk);
        resetn = 1'b1;
        rd(LBI_ENABLE_ADDR, 32'h0);
        rd(LBI_FLAGS_ADDR, 32'h0);
        for (int b = 0; b < 19; b++) begin
            fb = (b == 18) ? 12 : b;
            lvl = fb >= 2 && fb <= 8;
            m = 32'h1 << fb;
            wr(LBI_ENABLE_ADDR, 32'h0);
            ev_go(19'h1 << b);
            rd(LBI_FLAGS_ADDR, lvl ? 32'h0 : m);
            chk("local_irq", local_irq, 1'b0);
            wr(LBI_ENABLE_ADDR, m);
            if (lvl) ev_go(19'h1 << b);
            rd(LBI_FLAGS_ADDR, m);
            chk("local_irq", local_irq, 1'b1);
            chk("level_en", lvl_en, lvl ? 32'h1 << (8 - fb) : 32'h0);
            wr(LBI_FLAGS_ADDR, ~m);
            rd(LBI_FLAGS_ADDR, m);
            wr(LBI_FLAGS_ADDR, m);
            rd(LBI_FLAGS_ADDR, 32'h0);
            chk("local_irq", local_irq, 1'b0);
        end
        chk("irq_count", irq_count, 8'h13);
        wr(LBI_ENABLE_ADDR, 32'hffffffff);
        rd(LBI_ENABLE_ADDR, 32'h0003ffff);
        wr(12'h008, 32'h0);
        rd(LBI_ENABLE_ADDR, 32'h0003ffff);
        rd(12'h008, 32'h0);
        soft_request_pending = 1'b1;
        for (int v = 1; v >= 0; v--) begin
            @(negedge core_clk);
            soft_enable_wdata = v[0];
            soft_enable_write = 1'b1;
            @(negedge core_clk);
            soft_enable_write = 1'b0;
            chk("soft_out", soft_out, v[0]);
            chk("soft_en", soft_en, v[0]);
        end
        close_out();
    end
endmodule : tb_top
`default_nettype wire
